/* File: inc/pcr_pkg.sv */
package pcr_pkg;
  // register byte addresses
  localparam logic [11:0] ADDR_DEV_CTL2 = 12'h0e8;
  localparam logic [11:0] ADDR_LINK_CAP2 = 12'h0ec;
  localparam logic [11:0] ADDR_LINK_CTL2 = 12'h0f0;
  localparam logic [11:0] ADDR_SLOT_CAP2 = 12'h0f4;
  localparam logic [11:0] ADDR_SLOT_CTL2 = 12'h0f8;
  localparam logic [11:0] ADDR_ERR_HDR = 12'h100;
  localparam logic [11:0] ADDR_UNC_STAT = 12'h104;
  localparam logic [11:0] ADDR_RESET_CTL = 12'h200;

  // device control 2 fields
  localparam int LTR_EN_BIT = 10;
  localparam int OBFF_LO = 13;
  localparam logic [1:0] OBFF_RST = 2'h0;

  // link control 2 fields
  localparam int TLS_LO = 0;
  localparam logic [3:0] TLS_RST = 4'h2;
  localparam int CMPL_EN_BIT = 4;
  localparam int HW_SPD_BIT = 5;
  localparam int DEEMP_BIT = 6;
  localparam int MARGIN_LO = 7;
  localparam int MOD_CMPL_BIT = 10;
  localparam int CMPL_SOS_BIT = 11;
  localparam int CMPL_DEEMP_BIT = 12;
  localparam int CUR_DEEMP_BIT = 16;

  // error reporting header
  localparam logic [15:0] ERR_CAP_ID = 16'h0001;
  localparam logic [3:0] ERR_CAP_VER = 4'h1;
  localparam logic [11:0] ERR_NEXT_PTR = 12'h140;

  // uncorrectable status layout
  localparam logic [31:0] UNC_IMPL_MASK = 32'h003ff031;
  localparam int UNC_TRAIN = 0;
  localparam int UNC_DLP = 4;
  localparam int UNC_SDOWN = 5;
  localparam int UNC_POISON = 12;
  localparam int UNC_FCP = 13;
  localparam int UNC_CTO = 14;
  localparam int UNC_CA = 15;
  localparam int UNC_UCMP = 16;
  localparam int UNC_ROVF = 17;
  localparam int UNC_MALF = 18;
  localparam int UNC_ECRC = 19;
  localparam int UNC_UR = 20;
  localparam int UNC_ACS = 21;

  localparam int RESET_CTL_BIT = 0;

  typedef struct packed {
    logic train;
    logic dlp;
    logic sdown;
    logic poison_rx;
    logic poison_tx;
    logic fcp;
    logic cto;
    logic ca;
    logic ucmp;
    logic rovf;
    logic malf;
    logic ecrc;
    logic ur;
    logic acs;
  } pcr_err_ev_t;

  typedef struct packed {
    logic ltr_enable;
    logic [1:0] obff_enable;
    logic [3:0] target_speed;
    logic enter_compliance;
    logic hardware_speed_change_disable;
    logic deemphasis_select;
    logic [2:0] tx_margin;
    logic modified_compliance;
    logic compliance_sos;
    logic compliance_deemphasis;
  } pcr_ctl_t;
endpackage : pcr_pkg

/* File: design/pcr_err_flags.sv */
`timescale 1ns/100ps
// sticky write-one-to-clear flags, reset only by power-on reset
module pcr_err_flags #(
  parameter logic [31:0] IMPL = 32'h0
) (
  // clock and power-on reset
  input wire logic clk_sys,
  input wire logic por,
  // event pulses and clear strobes
  input wire logic [31:0] set_vec,
  input wire logic [31:0] clr_vec,
  // flags
  output logic [31:0] flags_r
);
  // set wins over a clear in the same cycle
  always_ff @(posedge clk_sys) begin
    if (por) begin
      flags_r <= 32'h0;
    end else begin
      flags_r <= ((flags_r & ~clr_vec) | set_vec) & IMPL;
    end
  end

  property p_hold;
    @(posedge clk_sys) disable iff (por)
      (set_vec == 32'h0 && clr_vec == 32'h0) |=> flags_r == $past(flags_r);
  endproperty
  a_hold: assert property (p_hold)
    else $error("flag changed without cause");
endmodule : pcr_err_flags

/* File: design/pcr_cfg_regs.sv */
`timescale 1ns/100ps
// Summary of operation
// - two-bit buffer flush enable field, read-write, resets to zero
// - deemphasis select reads 0 upstream, 1 downstream after reset
// - error header low half reads 0001h
// - error header bits 19:16 read version 1h
// - error header next pointer reads 140h
// - training error sets status bit 0, resets to zero
// - data link protocol error sets bit 4
// - surprise down sets bit 5, downstream ports only
// - poisoned packet received or generated sets bit 12
// - flow control protocol error sets bit 13
// - completion timeout sets bit 14
// - completer abort sets bit 15
// - unexpected completion sets bit 16
// - receiver overflow sets bit 17
// - malformed packet sets bit 18
// - end-to-end crc error sets bit 19
// - unsupported request sets bit 20
// - access control violation sets bit 21
module pcr_cfg_regs #(
  parameter bit DOWNSTREAM = 1'b0
) (
  // clock and resets
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic por,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // error events, one-cycle pulses from port logic
  input wire pcr_pkg::pcr_err_ev_t err_ev,
  input wire logic cur_deemphasis,
  // control outputs
  output pcr_pkg::pcr_ctl_t ctl,
  output logic [31:0] unc_status
);
  logic wr_en;
  logic rd_en;
  logic [31:0] wmask;
  logic [31:0] wval;
  logic [31:0] set_vec;
  logic [31:0] clr_vec;
  logic [31:0] rdata_nxt;
  logic hit;
  logic soft_reset_r;
  logic cfg_rst;
  logic ltr_en_r;
  logic [1:0] obff_en_r;
  logic [3:0] tls_r;
  logic cmpl_en_r;
  logic hw_spd_r;
  logic deemp_r;
  logic [2:0] margin_r;
  logic mod_cmpl_r;
  logic cmpl_sos_r;
  logic cmpl_deemp_r;

  function automatic logic [31:0] lane_mask(input logic [3:0] s);
    lane_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction : lane_mask

  // zero-wait slave: access phase completes in one cycle
  assign pready = 1'b1;
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & penable & ~pwrite;
  assign wmask = lane_mask(pstrb);
  assign wval = pwdata & wmask;

  // a software reset clears plain registers but not sticky ones
  assign cfg_rst = reset | soft_reset_r;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      soft_reset_r <= 1'b0;
    end else begin
      soft_reset_r <= wr_en && paddr == pcr_pkg::ADDR_RESET_CTL
        && wval[pcr_pkg::RESET_CTL_BIT];
    end
  end

  // device control 2
  always_ff @(posedge clk_sys) begin
    if (cfg_rst) begin
      ltr_en_r <= 1'b0;
      obff_en_r <= pcr_pkg::OBFF_RST;
    end else if (wr_en && paddr == pcr_pkg::ADDR_DEV_CTL2) begin
      if (wmask[pcr_pkg::LTR_EN_BIT]) begin
        ltr_en_r <= pwdata[pcr_pkg::LTR_EN_BIT];
      end
      if (wmask[pcr_pkg::OBFF_LO]) begin
        obff_en_r <= pwdata[pcr_pkg::OBFF_LO +: 2];
      end
    end
  end

  // link control 2, sticky fields survive all but power-on reset
  always_ff @(posedge clk_sys) begin
    if (por) begin
      tls_r <= pcr_pkg::TLS_RST;
      cmpl_en_r <= 1'b0;
      margin_r <= 3'h0;
      mod_cmpl_r <= 1'b0;
      cmpl_sos_r <= 1'b0;
      cmpl_deemp_r <= 1'b0;
    end else if (wr_en && paddr == pcr_pkg::ADDR_LINK_CTL2) begin
      if (wmask[pcr_pkg::TLS_LO]) begin
        tls_r <= pwdata[pcr_pkg::TLS_LO +: 4];
        cmpl_en_r <= pwdata[pcr_pkg::CMPL_EN_BIT];
      end
      if (wmask[pcr_pkg::MARGIN_LO]) begin
        margin_r[0] <= pwdata[pcr_pkg::MARGIN_LO];
      end
      if (wmask[pcr_pkg::MOD_CMPL_BIT]) begin
        margin_r[2:1] <= pwdata[pcr_pkg::MARGIN_LO + 1 +: 2];
        mod_cmpl_r <= pwdata[pcr_pkg::MOD_CMPL_BIT];
        cmpl_sos_r <= pwdata[pcr_pkg::CMPL_SOS_BIT];
        cmpl_deemp_r <= pwdata[pcr_pkg::CMPL_DEEMP_BIT];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (cfg_rst) begin
      hw_spd_r <= 1'b0;
    end else if (wr_en && paddr == pcr_pkg::ADDR_LINK_CTL2
        && wmask[pcr_pkg::HW_SPD_BIT]) begin
      hw_spd_r <= pwdata[pcr_pkg::HW_SPD_BIT];
    end
  end

  // read-only, fixed by port direction
  always_ff @(posedge clk_sys) begin
    if (cfg_rst) begin
      deemp_r <= DOWNSTREAM;
    end
  end

  // event to status bit mapping
  always_comb begin
    set_vec = 32'h0;
    set_vec[pcr_pkg::UNC_TRAIN] = err_ev.train;
    set_vec[pcr_pkg::UNC_DLP] = err_ev.dlp;
    set_vec[pcr_pkg::UNC_SDOWN] = err_ev.sdown & DOWNSTREAM;
    set_vec[pcr_pkg::UNC_POISON] = err_ev.poison_rx | err_ev.poison_tx;
    set_vec[pcr_pkg::UNC_FCP] = err_ev.fcp;
    set_vec[pcr_pkg::UNC_CTO] = err_ev.cto;
    set_vec[pcr_pkg::UNC_CA] = err_ev.ca;
    set_vec[pcr_pkg::UNC_UCMP] = err_ev.ucmp;
    set_vec[pcr_pkg::UNC_ROVF] = err_ev.rovf;
    set_vec[pcr_pkg::UNC_MALF] = err_ev.malf;
    set_vec[pcr_pkg::UNC_ECRC] = err_ev.ecrc;
    set_vec[pcr_pkg::UNC_UR] = err_ev.ur;
    set_vec[pcr_pkg::UNC_ACS] = err_ev.acs;
  end

  assign clr_vec = (wr_en && paddr == pcr_pkg::ADDR_UNC_STAT) ? wval : 32'h0;

  pcr_err_flags #(
    .IMPL(pcr_pkg::UNC_IMPL_MASK)
  ) i_pcr_err_flags (
    .clk_sys(clk_sys),
    .por(por),
    .set_vec(set_vec),
    .clr_vec(clr_vec),
    .flags_r(unc_status)
  );

  // read mux; unmapped words read zero
  always_comb begin
    rdata_nxt = 32'h0;
    hit = 1'b1;
    unique case (paddr)
      pcr_pkg::ADDR_DEV_CTL2: begin
        rdata_nxt[pcr_pkg::LTR_EN_BIT] = ltr_en_r;
        rdata_nxt[pcr_pkg::OBFF_LO +: 2] = obff_en_r;
      end
      pcr_pkg::ADDR_LINK_CTL2: begin
        rdata_nxt[pcr_pkg::TLS_LO +: 4] = tls_r;
        rdata_nxt[pcr_pkg::CMPL_EN_BIT] = cmpl_en_r;
        rdata_nxt[pcr_pkg::HW_SPD_BIT] = hw_spd_r;
        rdata_nxt[pcr_pkg::DEEMP_BIT] = deemp_r;
        rdata_nxt[pcr_pkg::MARGIN_LO +: 3] = margin_r;
        rdata_nxt[pcr_pkg::MOD_CMPL_BIT] = mod_cmpl_r;
        rdata_nxt[pcr_pkg::CMPL_SOS_BIT] = cmpl_sos_r;
        rdata_nxt[pcr_pkg::CMPL_DEEMP_BIT] = cmpl_deemp_r;
        rdata_nxt[pcr_pkg::CUR_DEEMP_BIT] = cur_deemphasis;
      end
      pcr_pkg::ADDR_ERR_HDR: begin
        rdata_nxt = {pcr_pkg::ERR_NEXT_PTR, pcr_pkg::ERR_CAP_VER,
          pcr_pkg::ERR_CAP_ID};
      end
      pcr_pkg::ADDR_UNC_STAT: begin
        rdata_nxt = unc_status & pcr_pkg::UNC_IMPL_MASK;
      end
      pcr_pkg::ADDR_LINK_CAP2, pcr_pkg::ADDR_SLOT_CAP2, pcr_pkg::ADDR_SLOT_CTL2,
      pcr_pkg::ADDR_RESET_CTL: begin
        rdata_nxt = 32'h0;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
  end

  // read data registered at the setup edge, valid during the access phase
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      prdata <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rdata_nxt;
    end
  end

  // unmapped addresses complete with an error, nothing stored
  assign pslverr = psel & penable & ~hit;

  always_comb begin
    ctl.ltr_enable = ltr_en_r;
    ctl.obff_enable = obff_en_r;
    ctl.target_speed = tls_r;
    ctl.enter_compliance = cmpl_en_r;
    ctl.hardware_speed_change_disable = hw_spd_r;
    ctl.deemphasis_select = deemp_r;
    ctl.tx_margin = margin_r;
    ctl.modified_compliance = mod_cmpl_r;
    ctl.compliance_sos = cmpl_sos_r;
    ctl.compliance_deemphasis = cmpl_deemp_r;
  end

  // assertions
  sequence s_hdr_setup;
    psel && !penable && !pwrite && paddr == pcr_pkg::ADDR_ERR_HDR;
  endsequence

  sequence s_stat_w1c;
    wr_en && paddr == pcr_pkg::ADDR_UNC_STAT;
  endsequence

  property p_obff_rst;
    @(posedge clk_sys) cfg_rst |=> obff_en_r == pcr_pkg::OBFF_RST;
  endproperty
  a_obff_rst: assert property (p_obff_rst)
    else $error("obff enable not zero after reset");

  property p_ltr_rst;
    @(posedge clk_sys) cfg_rst |=> !ltr_en_r;
  endproperty
  a_ltr_rst: assert property (p_ltr_rst)
    else $error("latency enable not zero after reset");

  property p_deemp;
    @(posedge clk_sys) disable iff (reset) deemp_r == DOWNSTREAM;
  endproperty
  a_deemp: assert property (p_deemp)
    else $error("deemphasis select wrong");

  property p_hdr;
    @(posedge clk_sys) disable iff (reset) s_hdr_setup |=>
      prdata == {pcr_pkg::ERR_NEXT_PTR, pcr_pkg::ERR_CAP_VER, pcr_pkg::ERR_CAP_ID};
  endproperty
  a_hdr: assert property (p_hdr)
    else $error("error header read wrong");

  property p_train;
    @(posedge clk_sys) disable iff (por) err_ev.train |=> unc_status[pcr_pkg::UNC_TRAIN];
  endproperty
  a_train: assert property (p_train)
    else $error("training flag not set");

  property p_dlp;
    @(posedge clk_sys) disable iff (por) err_ev.dlp |=> unc_status[pcr_pkg::UNC_DLP];
  endproperty
  a_dlp: assert property (p_dlp)
    else $error("link protocol flag not set");

  property p_sdown;
    @(posedge clk_sys) disable iff (por)
      err_ev.sdown |=> unc_status[pcr_pkg::UNC_SDOWN] == DOWNSTREAM;
  endproperty
  a_sdown: assert property (p_sdown)
    else $error("surprise down flag wrong for port direction");

  property p_poison;
    @(posedge clk_sys) disable iff (por)
      (err_ev.poison_rx || err_ev.poison_tx) |=> unc_status[pcr_pkg::UNC_POISON];
  endproperty
  a_poison: assert property (p_poison)
    else $error("poison flag not set");

  property p_fcp;
    @(posedge clk_sys) disable iff (por) err_ev.fcp |=> unc_status[pcr_pkg::UNC_FCP];
  endproperty
  a_fcp: assert property (p_fcp)
    else $error("flow control flag not set");

  property p_set;
    @(posedge clk_sys) disable iff (por) err_ev.cto |=> unc_status[pcr_pkg::UNC_CTO];
  endproperty
  a_set: assert property (p_set)
    else $error("timeout flag not set");

  property p_abort;
    @(posedge clk_sys) disable iff (por) err_ev.ca |=> unc_status[pcr_pkg::UNC_CA];
  endproperty
  a_abort: assert property (p_abort)
    else $error("completer abort flag not set");

  property p_ucmp;
    @(posedge clk_sys) disable iff (por) err_ev.ucmp |=> unc_status[pcr_pkg::UNC_UCMP];
  endproperty
  a_ucmp: assert property (p_ucmp)
    else $error("unexpected completion flag not set");

  property p_ovf;
    @(posedge clk_sys) disable iff (por) err_ev.rovf |=> unc_status[pcr_pkg::UNC_ROVF];
  endproperty
  a_ovf: assert property (p_ovf)
    else $error("receiver overflow flag not set");

  property p_acs;
    @(posedge clk_sys) disable iff (por) err_ev.acs |=> unc_status[pcr_pkg::UNC_ACS];
  endproperty
  a_acs: assert property (p_acs)
    else $error("access violation flag not set");

  property p_clear;
    @(posedge clk_sys) disable iff (por)
      (s_stat_w1c ##0 set_vec == 32'h0) |=> (unc_status & $past(wval)) == 32'h0;
  endproperty
  a_clear: assert property (p_clear)
    else $error("flag written with one not cleared");

  property p_rsvd;
    @(posedge clk_sys) disable iff (por) (unc_status & ~pcr_pkg::UNC_IMPL_MASK) == 32'h0;
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("reserved status bit set");

  property p_unmapped_rd;
    @(posedge clk_sys) disable iff (reset) (rd_en && !hit) |-> prdata == 32'h0;
  endproperty
  a_unmapped_rd: assert property (p_unmapped_rd)
    else $error("unmapped read not zero");

  property p_tls_sticky;
    @(posedge clk_sys) disable iff (por)
      (reset && !(wr_en && paddr == pcr_pkg::ADDR_LINK_CTL2)) |=> $stable(tls_r);
  endproperty
  a_tls_sticky: assert property (p_tls_sticky)
    else $error("target speed lost on reset");
endmodule : pcr_cfg_regs

/* File: bench/pcr_cfg_regs_test.sv */
`timescale 1ns/100ps
module pcr_cfg_regs_test;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic por = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic cur_deemphasis = 1'b0;
  pcr_pkg::pcr_err_ev_t err_ev = '0;
  logic [31:0] prdata;
  logic [31:0] unc_status;
  logic pready;
  logic pslverr;
  pcr_pkg::pcr_ctl_t ctl;
  logic [32:0] exp_q[$];
  logic [32:0] note;
  logic [31:0] lfsr = 32'h1a;
  logic [31:0] w;
  logic [31:0] lw;
  logic [31:0] ev_exp;
  int err_total = 0;
  int samples_checked = 0;
  // status bit for each event field, struct bit 0 (acs) first
  int unc_bit [14] = '{21, 20, 19, 18, 17, 16, 15, 14, 13, 12, 12, 5, 4, 0};
  // read-only words that must ignore writes
  logic [11:0] ro_addr [3] = '{pcr_pkg::ADDR_LINK_CAP2, pcr_pkg::ADDR_SLOT_CAP2,
    pcr_pkg::ADDR_SLOT_CTL2};

  always #2.5 clk_sys = ~clk_sys;

  pcr_cfg_regs #(.DOWNSTREAM(1'b1)) i_pcr_cfg_regs (
    .clk_sys(clk_sys), .reset(reset), .por(por), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .err_ev(err_ev),
    .cur_deemphasis(cur_deemphasis), .ctl(ctl), .unc_status(unc_status)
  );

  task report_and_stop;
    if (err_total == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop

  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  function automatic logic [31:0] rnd_step(input logic [31:0] s);
    rnd_step = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : rnd_step

  task get_rnd(output logic [31:0] r);
    repeat (32) lfsr = rnd_step(lfsr);
    r = lfsr;
  endtask : get_rnd

  // read results are judged only at the edge that ends the access phase
  always @(posedge clk_sys) begin
    if (psel && penable && !pwrite && pready === 1'b1) begin
      note = exp_q.pop_front();
      samples_checked++;
      if ({pslverr, prdata} !== note) begin
        err_total++;
        $display("ERROR %0t got %h exp %h", $time, {pslverr, prdata}, note);
      end
    end
  end

  task apb(input logic is_wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= is_wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      err_total++;
      report_and_stop();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb

  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hf);
  endtask : wr

  task rd(input logic [11:0] a, input logic [31:0] e, input logic se = 1'b0);
    exp_q.push_back({se, e});
    apb(1'b0, a, 32'h0, 4'hf);
  endtask : rd

  task ev(input logic [13:0] v);
    err_ev <= pcr_pkg::pcr_err_ev_t'(v);
    @(posedge clk_sys);
    err_ev <= '0;
    @(posedge clk_sys);
  endtask : ev

  initial begin
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    por <= 1'b0;
    @(posedge clk_sys);
    rd(pcr_pkg::ADDR_DEV_CTL2, 32'h0);
    rd(pcr_pkg::ADDR_LINK_CTL2, 32'h42);
    rd(pcr_pkg::ADDR_ERR_HDR, 32'h14010001);
    rd(pcr_pkg::ADDR_UNC_STAT, 32'h0);
    foreach (ro_addr[i]) begin
      wr(ro_addr[i], 32'hffffffff);
      rd(ro_addr[i], 32'h0);
    end
    wr(12'h0fc, 32'hffffffff);
    rd(12'h0fc, 32'h0, 1'b1);
    get_rnd(w);
    wr(pcr_pkg::ADDR_DEV_CTL2, w);
    chk(32'({ctl.ltr_enable, ctl.obff_enable}), 32'({w[10], w[14:13]}));
    rd(pcr_pkg::ADDR_DEV_CTL2, w & 32'h6400);
    apb(1'b1, pcr_pkg::ADDR_DEV_CTL2, ~w, 4'h0);
    rd(pcr_pkg::ADDR_DEV_CTL2, w & 32'h6400);
    // software reset returns the plain fields to their reset values
    wr(pcr_pkg::ADDR_RESET_CTL, 32'h1);
    rd(pcr_pkg::ADDR_DEV_CTL2, 32'h0);
    chk(32'({ctl.ltr_enable, ctl.obff_enable}), 32'h0);
    cur_deemphasis <= 1'b1;
    get_rnd(lw);
    wr(pcr_pkg::ADDR_LINK_CTL2, lw);
    chk(32'({ctl.target_speed, ctl.deemphasis_select}), 32'({lw[3:0], 1'b1}));
    rd(pcr_pkg::ADDR_LINK_CTL2, (lw & 32'h1fbf) | 32'h10040);
    wr(pcr_pkg::ADDR_ERR_HDR, 32'h0);
    rd(pcr_pkg::ADDR_ERR_HDR, 32'h14010001);
    // each event alone, then write zero, then write one to clear
    foreach (unc_bit[i]) begin
      ev(14'(1 << i));
      rd(pcr_pkg::ADDR_UNC_STAT, 32'h1 << unc_bit[i]);
      wr(pcr_pkg::ADDR_UNC_STAT, ~(32'h1 << unc_bit[i]));
      rd(pcr_pkg::ADDR_UNC_STAT, 32'h1 << unc_bit[i]);
      wr(pcr_pkg::ADDR_UNC_STAT, 32'h1 << unc_bit[i]);
      rd(pcr_pkg::ADDR_UNC_STAT, 32'h0);
    end
    get_rnd(w);
    ev_exp = 32'h0;
    foreach (unc_bit[i]) begin
      if (w[i])
        ev_exp[unc_bit[i]] = 1'b1;
    end
    ev(w[13:0]);
    chk(unc_status, ev_exp);
    rd(pcr_pkg::ADDR_UNC_STAT, ev_exp);
    // plain reset keeps sticky state, power-on reset clears it
    reset <= 1'b1;
    @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    rd(pcr_pkg::ADDR_UNC_STAT, ev_exp);
    rd(pcr_pkg::ADDR_LINK_CTL2, (lw & 32'h1f9f) | 32'h10040);
    rd(pcr_pkg::ADDR_DEV_CTL2, 32'h0);
    reset <= 1'b1;
    por <= 1'b1;
    @(posedge clk_sys);
    reset <= 1'b0;
    por <= 1'b0;
    @(posedge clk_sys);
    rd(pcr_pkg::ADDR_UNC_STAT, 32'h0);
    rd(pcr_pkg::ADDR_LINK_CTL2, 32'h10042);
    chk(unc_status, 32'h0);
    chk(32'(ctl.target_speed), 32'(pcr_pkg::TLS_RST));
    report_and_stop();
  end
endmodule : pcr_cfg_regs_test
